// [core/ccdr_pkg.sv]
// Constants and types for the full-frame CCD readout timing controller
// Summary of operation
// - Wide-range output: gate A copies horizontal phase two, gate B held low.
// - High-sensitivity output: gate B copies horizontal phase two, gate A held low.
// - Reset clock toggles continuously, also during integration and vertical shifts.
// - A frame readout is 520 consecutive line times.
// - A line is 3 vertical intervals, one set-up interval, 531 pixel periods.
// - Pixel period at least 125 ns, nominally 200 ns.
// - Horizontal clocks at most 8 MHz, nominally 5 MHz.
// - Vertical clocks at most 125 kHz, nominally 100 kHz.
// - Vertical and horizontal clocks run at 50% duty cycle.
// - Each vertical pulse at least 4 us, nominally 5 us.
// - Each reset pulse at least 10 ns, nominally 20 ns.
// - Wait a horizontal set-up interval after vertical transfer before horizontal clocking.
// - Integration time is programmable by the user.
// - Both vertical phases held low during integration.
// - Line shift: raise V1, invert both, transition again, lower V1.
// - Horizontal phases complementary while reading a line.
package ccdr_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PIX_PERIOD_NS = 200;
	localparam int PIX_CYC       = PIX_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PIX_HALF      = PIX_CYC / 2;
	localparam int VPULSE_US     = 5;
	localparam int VPULSE_CYC    = VPULSE_US * 1000 / CLK_PERIOD_NS;
	// The larger printed set-up figure is taken so both readings are met
	localparam int HSETUP_NS     = 500;
	localparam int HSETUP_CYC    = (HSETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RSTPULSE_NS   = 20;
	localparam int RSTPULSE_CYC  = RSTPULSE_NS / CLK_PERIOD_NS;
	// Reset pulse sits in the phase-two-high half, ahead of its fall
	localparam int RST_AT        = PIX_HALF + 2;
	localparam int SAMPLE_AT     = PIX_HALF - 2;

	// ----------------------------------------
	// Frame geometry
	// ----------------------------------------
	localparam int V_INTERVALS   = 3;
	localparam int LINE_PIXELS   = 530 + 1;
	localparam int FRAME_LINES   = 520;
	localparam int DATA_W        = 16;
	localparam int INTEG_W       = 32;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_INTEG  = 5'b00010,
		ST_VSHIFT = 5'b00100,
		ST_HSETUP = 5'b01000,
		ST_HREAD  = 5'b10000
	} ccdr_state_t;

endpackage

// [core/ccdr_stream_if.sv]
// Valid/ready word stream between the controller and its buffer
`timescale 1ns/1ps
`default_nettype none
interface ccdr_stream_if;
	import ccdr_pkg::*;
	logic [DATA_W-1:0] data;
	logic              valid;
	logic              ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// [core/ccdr_skid_buf.sv]
// Two-entry word buffer with registered head
`timescale 1ns/1ps
`default_nettype none
module ccdr_skid_buf
	import ccdr_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     nrst,
	ccdr_stream_if.snk    in_s,
	ccdr_stream_if.src    out_s
);
	logic [DATA_W-1:0] head_q;
	logic [DATA_W-1:0] tail_q;
	logic [1:0]        cnt_q;
	logic              push;
	logic              pop;
	logic              vld_q;

	assign in_s.ready  = (cnt_q != 2'h2);
	assign out_s.valid = vld_q;
	assign out_s.data  = head_q;
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			cnt_q <= 2'h0;
		else if (push && !pop)
			cnt_q <= cnt_q + 2'h1;
		else if (pop && !push)
			cnt_q <= cnt_q - 2'h1;
	end

	// Own flop for valid, so the valid pin is not a decode of the count
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			vld_q <= 1'b0;
		else if (push && !pop)
			vld_q <= 1'b1;
		else if (pop && !push)
			vld_q <= (cnt_q == 2'h2);
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			head_q <= '0;
			tail_q <= '0;
		end
		else
		begin
			case ({push, pop})
				2'b10:
				begin
					if (cnt_q == 2'h0)
						head_q <= in_s.data;
					else
						tail_q <= in_s.data;
				end
				2'b01:
					head_q <= tail_q;
				2'b11:
				begin
					if (cnt_q == 2'h1)
						head_q <= in_s.data;
					else
					begin
						head_q <= tail_q;
						tail_q <= in_s.data;
					end
				end
				default:
					head_q <= head_q;
			endcase
		end
	end
endmodule
`default_nettype wire

// [core/ccdr_readout.sv]
// Frame readout clock sequencer for a two-phase full-frame CCD
`timescale 1ns/1ps
`default_nettype none
module ccdr_readout
	import ccdr_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               nrst,
	input  wire logic               start,
	input  wire logic               hs_mode,
	input  wire logic [INTEG_W-1:0] integ_cycles,
	input  wire logic [DATA_W-1:0]  adc_data,
	input  wire logic               pix_ready,
	output logic [DATA_W-1:0]       pix_data,
	output logic                    pix_valid,
	output logic                    vertical_phase_one,
	output logic                    vertical_phase_two,
	output logic                    horizontal_phase_one,
	output logic                    horizontal_phase_two,
	output logic                    split_final_gate_a,
	output logic                    split_final_gate_b,
	output logic                    reset_clock,
	output logic                    busy,
	output logic                    frame_done
);
	// ----------------------------------------
	// State and counters
	// ----------------------------------------
	ccdr_state_t        state_q;
	logic [4:0]         pcnt_q;
	logic [INTEG_W-1:0] tcnt_q;
	logic [INTEG_W-1:0] integ_q;
	logic [1:0]         vph_q;
	logic [9:0]         pix_q;
	logic [9:0]         line_q;
	logic               mode_q;
	logic               hold_q;
	logic               pix_end;
	logic               run_end;

	ccdr_stream_if      fill_s ();
	ccdr_stream_if      drain_s ();

	assign pix_end = (pcnt_q == 5'(PIX_CYC - 1));
	assign run_end = (state_q == ST_HREAD) && pix_end && !hold_q;

	// Free-running pixel phase, so the reset clock never stops
	always_ff @(posedge core_clk)
	begin
		if (!nrst || pix_end)
			pcnt_q <= 5'h0;
		else
			pcnt_q <= pcnt_q + 5'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
			tcnt_q  <= '0;
			vph_q   <= 2'h0;
			pix_q   <= 10'h0;
			line_q  <= 10'h0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (start)
					begin
						state_q <= ST_INTEG;
						tcnt_q  <= '0;
						line_q  <= 10'h0;
					end
				end
				ST_INTEG:
				begin
					tcnt_q <= tcnt_q + 1'b1;
					if (tcnt_q + 1'b1 >= integ_q)
					begin
						state_q <= ST_VSHIFT;
						tcnt_q  <= '0;
						vph_q   <= 2'h0;
					end
				end
				ST_VSHIFT:
				begin
					tcnt_q <= tcnt_q + 1'b1;
					if (tcnt_q == INTEG_W'(VPULSE_CYC - 1))
					begin
						tcnt_q <= '0;
						vph_q  <= vph_q + 2'h1;
						if (vph_q == 2'(V_INTERVALS - 1))
							state_q <= ST_HSETUP;
					end
				end
				ST_HSETUP:
				begin
					if (tcnt_q < INTEG_W'(HSETUP_CYC))
						tcnt_q <= tcnt_q + 1'b1;
					// Start on a pixel boundary to keep reset aligned
					if (tcnt_q >= INTEG_W'(HSETUP_CYC - 1) && pix_end)
					begin
						state_q <= ST_HREAD;
						pix_q   <= 10'h0;
					end
				end
				ST_HREAD:
				begin
					if (run_end)
					begin
						pix_q <= pix_q + 10'h1;
						if (pix_q == 10'(LINE_PIXELS - 1))
						begin
							line_q <= line_q + 10'h1;
							tcnt_q <= '0;
							vph_q  <= 2'h0;
							if (line_q == 10'(FRAME_LINES - 1))
								state_q <= ST_IDLE;
							else
								state_q <= ST_VSHIFT;
						end
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Mode and exposure are latched so they cannot change mid-frame
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			mode_q  <= 1'b0;
			integ_q <= '0;
		end
		else if (state_q == ST_IDLE && start)
		begin
			mode_q  <= hs_mode;
			integ_q <= integ_cycles;
		end
	end

	// A full buffer freezes the next pixel with phase two high, so no packet
	// reaches the output node and nothing is lost; costs one pixel period for each period the buffer stays full.
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			hold_q <= 1'b0;
		else if (state_q == ST_HREAD && pix_end)
			hold_q <= !fill_s.ready;
		else if (state_q != ST_HREAD)
			hold_q <= 1'b0;
	end

	// ----------------------------------------
	// Clock outputs
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			vertical_phase_one   <= 1'b0;
			vertical_phase_two   <= 1'b0;
			horizontal_phase_one <= 1'b0;
			horizontal_phase_two <= 1'b0;
			split_final_gate_a   <= 1'b0;
			split_final_gate_b   <= 1'b0;
			reset_clock          <= 1'b0;
		end
		else
		begin
			// Low outside the shift, high for V1 then V2 then V1
			vertical_phase_one <= (state_q == ST_VSHIFT) && (vph_q != 2'h1);
			vertical_phase_two <= (state_q == ST_VSHIFT) && (vph_q == 2'h1);
			// Complementary halves of one pixel period
			horizontal_phase_one <= (state_q == ST_HREAD) && !hold_q &&
				(pcnt_q < 5'(PIX_HALF));
			horizontal_phase_two <= (state_q == ST_HREAD) &&
				(hold_q || pcnt_q >= 5'(PIX_HALF));
			split_final_gate_a   <= !mode_q && (state_q == ST_HREAD) &&
				(hold_q || pcnt_q >= 5'(PIX_HALF));
			split_final_gate_b   <= mode_q && (state_q == ST_HREAD) &&
				(hold_q || pcnt_q >= 5'(PIX_HALF));
			reset_clock <= (pcnt_q >= 5'(RST_AT)) &&
				(pcnt_q < 5'(RST_AT + RSTPULSE_CYC));
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			busy       <= 1'b0;
			frame_done <= 1'b0;
		end
		else
		begin
			busy       <= (state_q != ST_IDLE);
			frame_done <= run_end && (pix_q == 10'(LINE_PIXELS - 1)) &&
				(line_q == 10'(FRAME_LINES - 1));
		end
	end

	// ----------------------------------------
	// Sample path
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			fill_s.valid <= 1'b0;
			fill_s.data  <= '0;
		end
		else
		begin
			fill_s.valid <= (state_q == ST_HREAD) && !hold_q &&
				(pcnt_q == 5'(SAMPLE_AT));
			fill_s.data  <= adc_data;
		end
	end

	ccdr_skid_buf u_buf (
		.core_clk (core_clk),
		.nrst     (nrst),
		.in_s     (fill_s),
		.out_s    (drain_s)
	);

	assign pix_data      = drain_s.data;
	assign pix_valid     = drain_s.valid;
	assign drain_s.ready = pix_ready;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic [9:0]  h1_len_q;
	logic [9:0]  v1_len_q;
	logic [9:0]  since_v_q;
	logic [4:0]  since_r_q;
	logic [9:0]  lines_q;
	logic [INTEG_W-1:0] int_len_q;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			h1_len_q  <= 10'h0;
			v1_len_q  <= 10'h0;
			since_v_q <= 10'h0;
			since_r_q <= 5'h0;
			lines_q   <= 10'h0;
			int_len_q <= '0;
		end
		else
		begin
			h1_len_q  <= horizontal_phase_one ? h1_len_q + 10'h1 : 10'h0;
			v1_len_q  <= vertical_phase_one ? v1_len_q + 10'h1 : 10'h0;
			since_v_q <= (vertical_phase_one || vertical_phase_two) ? 10'h0 :
				(since_v_q == 10'h3ff ? since_v_q : since_v_q + 10'h1);
			since_r_q <= $rose(reset_clock) ? 5'h0 :
				(since_r_q == 5'h1f ? since_r_q : since_r_q + 5'h1);
			if (state_q == ST_IDLE)
				lines_q <= 10'h0;
			else if (state_q == ST_HSETUP && $past(state_q) != ST_HSETUP)
				lines_q <= lines_q + 10'h1;
			int_len_q <= (state_q == ST_INTEG) ? int_len_q + 1'b1 : '0;
		end
	end

	gate_a_mode_a: assert property (!mode_q |-> !split_final_gate_b &&
		split_final_gate_a == horizontal_phase_two)
		else $error("gate A does not follow phase two");
	gate_b_mode_a: assert property (mode_q |-> !split_final_gate_a &&
		split_final_gate_b == horizontal_phase_two)
		else $error("gate B does not follow phase two");
	reset_period_a: assert property ($rose(reset_clock) |-> ##20 $rose(reset_clock))
		else $error("reset clock stopped or drifted");
	reset_width_a: assert property ($rose(reset_clock) |-> reset_clock[*2] ##1 !reset_clock)
		else $error("reset pulse width wrong");
	frame_lines_a: assert property (frame_done |-> lines_q == 10'(FRAME_LINES))
		else $error("frame line count wrong");
	line_pixels_a: assert property (run_end && pix_q == 10'(LINE_PIXELS - 1) |=>
		state_q != ST_HREAD)
		else $error("line did not end after its pixels");
	h_half_period_a: assert property ($fell(horizontal_phase_one) |->
		h1_len_q == 10'(PIX_HALF))
		else $error("horizontal half period wrong");
	v_pulse_len_a: assert property ($fell(vertical_phase_one) |->
		v1_len_q == 10'(VPULSE_CYC))
		else $error("vertical pulse width wrong");
	h_setup_gap_a: assert property ($rose(horizontal_phase_one) |->
		since_v_q >= 10'(HSETUP_CYC))
		else $error("horizontal set-up too short");
	integ_len_a: assert property (state_q == ST_INTEG && $past(state_q) == ST_INTEG &&
		int_len_q != 0 |-> int_len_q < integ_q)
		else $error("integration overran");
	integ_quiet_a: assert property (state_q == ST_INTEG && $past(state_q) == ST_INTEG |->
		!vertical_phase_one && !vertical_phase_two)
		else $error("vertical clock moved in integration");
	v_order_a: assert property ($rose(vertical_phase_two) |-> $fell(vertical_phase_one))
		else $error("vertical phases out of order");
	h_compl_a: assert property (!(horizontal_phase_one && horizontal_phase_two))
		else $error("horizontal phases overlap");
	reset_before_a: assert property ($fell(horizontal_phase_two) |->
		since_r_q < 5'(PIX_HALF))
		else $error("no reset pulse before phase two fall");

	frame_end_c: cover property (frame_done);
	stall_c: cover property (hold_q && state_q == ST_HREAD);
	hs_read_c: cover property (mode_q && split_final_gate_b);
endmodule
`default_nettype wire

// [bench/ccdr_sensor_model.sv]
// Behavioural sensor: serial register, split final gate, output node
`timescale 1ns/1ps
`default_nettype none
module ccdr_sensor_model
	import ccdr_pkg::*;
#(
	parameter logic [DATA_W-1:0] RST_LVL = 16'hffff
)(
	input  wire logic              core_clk,
	input  wire logic              power_ok,
	input  wire logic              hs_sel,
	input  wire logic              vertical_phase_two,
	input  wire logic              split_final_gate_a,
	input  wire logic              split_final_gate_b,
	input  wire logic              reset_clock,
	output logic [DATA_W-1:0]      video
);
	logic [5:0] row_q;
	logic [5:0] nrow_q;
	logic [9:0] col_q;
	logic       v2_p;
	logic       gate_p;
	wire  logic act = hs_sel ? split_final_gate_b : split_final_gate_a;
	wire  logic stat = hs_sel ? split_final_gate_a : split_final_gate_b;

	always @(posedge core_clk)
	begin
		v2_p <= vertical_phase_two;
		gate_p <= act;
		if (!power_ok)
		begin
			nrow_q <= '0;
			col_q <= '0;
			video <= ~RST_LVL;
		end
		else
		begin
			if (vertical_phase_two && !v2_p)
			begin
				row_q <= nrow_q;
				nrow_q <= nrow_q + 6'h1;
				col_q <= '0;
			end
			// Blocking gate left high splits the packet: output is garbage
			if (stat)
				video <= ~video;
			else if (reset_clock)
				video <= RST_LVL;
			else if (gate_p && !act)
			begin
				video <= {row_q, col_q};
				col_q <= col_q + 10'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [bench/ccdr_readout_bench.sv]
// Self-checking bench for the CCD readout sequencer
`timescale 1ns/1ps
`default_nettype none
module ccdr_readout_bench;
	import ccdr_pkg::*;
	localparam logic [DATA_W-1:0] RST_LVL = 16'hffff;
	logic core_clk = 0, nrst = 0, start = 0, hs_mode = 0, pix_ready = 0;
	logic [INTEG_W-1:0] integ_cycles = '0;
	logic [DATA_W-1:0] adc_data, pix_data;
	logic pix_valid, v1, v2, h1, h2, ga, gb, rc, busy, frame_done;
	logic v1p, v2p, h1p, h2p, rcp, bsp;
	int bad_count = 0, cmp_count = 0;
	int cyc, st, dly, got, rdy, ln, wk, hc, vl, su, d0, d1, r, i;
	int v1r, v2r, h1r, h2r, rcw, rcg, rcs, rch;

	ccdr_readout u_ccdr_readout (.core_clk(core_clk), .nrst(nrst), .start(start),
		.hs_mode(hs_mode), .integ_cycles(integ_cycles), .adc_data(adc_data),
		.pix_ready(pix_ready), .pix_data(pix_data), .pix_valid(pix_valid),
		.vertical_phase_one(v1), .vertical_phase_two(v2), .horizontal_phase_one(h1),
		.horizontal_phase_two(h2), .split_final_gate_a(ga), .split_final_gate_b(gb),
		.reset_clock(rc), .busy(busy), .frame_done(frame_done));
	ccdr_sensor_model #(.RST_LVL(RST_LVL)) u_ccdr_sensor_model (.core_clk(core_clk),
		.power_ok(nrst), .hs_sel(hs_mode), .vertical_phase_two(v2), .split_final_gate_a(ga),
		.split_final_gate_b(gb), .reset_clock(rc), .video(adc_data));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic run(input logic hs, input int n);
		@(posedge core_clk);
		start <= 1'b1;
		hs_mode <= hs;
		integ_cycles <= INTEG_W'(n);
		@(posedge core_clk);
		start <= 1'b0;
	endtask

	task automatic rst;
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("rst_outs", {v1, v2, h1, h2, ga, gb, rc, busy, pix_valid}, 0);
		@(posedge core_clk);
		nrst <= 1'b1;
	endtask

	initial forever #5 core_clk = ~core_clk;

	// ----
	// Watcher and line model
	// ----
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		pix_ready <= (rdy == 0) ? 1'b1 : (rdy == 1) ? 1'($urandom % 2) : 1'b0;
		{v1p, v2p, h1p, h2p, rcp, bsp} <= {v1, v2, h1, h2, rc, busy};
		v1r <= v1 ? v1r + 1 : 0;
		v2r <= v2 ? v2r + 1 : 0;
		h1r <= h1 ? h1r + 1 : 0;
		h2r <= h2 ? h2r + 1 : 0;
		rcw <= rc ? rcw + 1 : 0;
		rcg <= (rc && !rcp) ? 1 : rcg + 1;
		if (!nrst)
		begin
			{got, ln, wk, hc, vl, rcs, rch} <= '0;
			su <= -1;
		end
		else
		begin
			if (start && !busy)
			begin
				st <= cyc;
				got <= 0;
			end
			else if (v1 && !v1p && !got)
			begin
				dly <= cyc - st;
				got <= 1;
			end
			if (busy && !got) chk("vert_integ", v2, 0);
			if (busy && !bsp) chk("busy_rise", cyc - st, 2);
			if (v1p && !v1) chk("v1_width", v1r, VPULSE_CYC);
			if (v2p && !v2) chk("v2_width", v2r, VPULSE_CYC);
			if (v2 && !v2p) chk("v_swap", {v1p, v1}, 2'b10);
			if (v2 && !v2p)
			begin
				if (vl > 0) chk("line_pix", hc, LINE_PIXELS);
				hc <= 0;
				vl <= vl + 1;
			end
			if (su >= 0) su <= su + 1;
			if (v1p && !v1) su <= 0;
			if (h1 && !h1p)
			begin
				hc <= hc + 1;
				if (su >= 0) chk("setup", su >= HSETUP_CYC - 1 && su < HSETUP_CYC + PIX_CYC, 1);
				su <= -1;
			end
			if (h1p && !h1) chk("h1_high", h1r, PIX_HALF);
			if (h2p && !h2) chk("h2_high", h2r % PIX_HALF, 0);
			if (h2p && !h2) chk("rst_first", rch, 1);
			if (rc && !rcp) rch <= 1;
			if (h2 && !h2p) rch <= 0;
			chk("h_compl", h1 && h2, 0);
			chk("gate_a", ga, hs_mode ? 1'b0 : h2);
			chk("gate_b", gb, hs_mode ? h2 : 1'b0);
			chk("frame_end", frame_done, 0);
			if (rc && !rcp && rcs) chk("rst_period", rcg, PIX_CYC);
			if (rc && !rcp) rcs <= 1;
			if (rcp && !rc) chk("rst_width", rcw, RSTPULSE_CYC);
			if (pix_valid && pix_ready)
			begin
				chk("pix_data", pix_data, wk == 0 ? RST_LVL : {ln[5:0], 10'(wk - 1)});
				wk <= (wk == LINE_PIXELS - 1) ? 0 : wk + 1;
				if (wk == LINE_PIXELS - 1) ln <= ln + 1;
			end
		end
	end

	// Far longer than the three runs need
	initial
	begin
		#800000;
		bad_count++;
		close_out;
	end

	initial
	begin
		void'($urandom(32'h03b6ea47));
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		run(1'b0, 0);
		for (i = 0; i < 3000 && hc < 20; i++) @(posedge core_clk);
		rdy <= 2;
		repeat (400) @(posedge core_clk);
		rdy <= 1;
		for (i = 0; i < 40000 && ln < 2; i++) @(posedge core_clk);
		chk("lines_wide", ln, 2);
		d0 = dly;
		rst;
		rdy <= 0;
		run(1'b1, 1);
		for (i = 0; i < 20000 && wk < 40; i++) @(posedge core_clk);
		chk("words_hs", wk, 40);
		d1 = dly;
		chk("integ_zero", d0, d1);
		rst;
		r = 2 + $urandom % 200;
		run(1'b0, r);
		@(posedge core_clk);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		for (i = 0; i < 3000 && !got; i++) @(posedge core_clk);
		chk("integ_len", dly - d1, r - 1);
		close_out;
	end
endmodule
`default_nettype wire
